// >>> hdl/sacs_top.v
// Converter control sequencer with Avalon-MM register slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sacs_consts.vh"
module sacs_top #(
  parameter RC_DIV = 40
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg analog_power_on,
  output reg [1:0] mux_channel,
  output reg ref_ext_sel,
  output reg sample_en,
  output reg sar_trial_en,
  output reg [3:0] sar_bit_idx,
  input wire comparator_out,
  output reg [3:0] pin_analog_select,
  output reg [3:0] pin_digital_disable,
  output reg conv_irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_ABORT = 2'd2;
  reg [7:0] converter_control_reg;
  reg [7:0] analog_pin_select_reg;
  reg [7:0] result_high;
  reg [7:0] result_low;
  reg conversion_done_flag;
  reg done_irq_en;
  reg [1:0] state;
  reg [3:0] tad_cnt;
  reg [9:0] sar_word;
  reg [1:0] conv_channel;
  reg ack;
  reg cmp_s1, cmp_s2, cmp_s3;
  reg cmp_val;
  wire tad_tick;
  wire go = converter_control_reg[`SACS_B_GO];
  wire on = converter_control_reg[`SACS_B_ON];
  wire req = avs_read | avs_write;
  wire wr = avs_write & ack & avs_byteenable[0];
  // Read data load in the stall cycle so they stand at the accepting edge
  wire rd = avs_read & ~ack;
  wire wr_ctrl = wr & (avs_address == `SACS_OFS_CTRL);
  wire [7:0] wdata = avs_writedata[7:0];
  wire finish = (state == ST_CONV) & tad_tick & (tad_cnt == `SACS_CONV_TAD - 4'd1);
  wire sw_abort = (state == ST_CONV) & wr_ctrl & ~wdata[`SACS_B_GO];
  wire abort_now = (state == ST_CONV) & (sw_abort | ~on);
  // One wait state: request is accepted on the second edge
  assign avs_waitrequest = req & ~ack;
  sacs_tad_gen #(
    .RC_DIV(RC_DIV)
  ) u_tad (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    // Divider restarts on abort so the abort wait spans whole bit periods
    .run((state != ST_IDLE) & ~abort_now),
    .clk_sel(analog_pin_select_reg[`SACS_B_CS_HI:`SACS_B_CS_LO]),
    .tad_tick(tad_tick)
  );
  // Comparator is asynchronous to the sequencer
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_val <= 1'b0;
    end else begin
      cmp_s1 <= comparator_out;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3)
        cmp_val <= cmp_s3;
    end
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= req & ~ack;
  end
  // Register writes and sequencer share one process so go has a single driver
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      converter_control_reg <= `SACS_CTRL_RST;
      analog_pin_select_reg <= `SACS_PINSEL_RST;
      result_high <= 8'h00;
      result_low <= 8'h00;
      conversion_done_flag <= 1'b0;
      done_irq_en <= 1'b0;
      state <= ST_IDLE;
      tad_cnt <= 4'd0;
      sar_word <= 10'd0;
      conv_channel <= 2'd0;
    end else begin
      if (wr_ctrl)
        converter_control_reg <= wdata & `SACS_CTRL_MASK; // [RL16]
      if (wr & (avs_address == `SACS_OFS_PINSEL))
        analog_pin_select_reg <= wdata & `SACS_PINSEL_MASK; // [RL2] [RL16] [RL14]
      if (wr & (avs_address == `SACS_OFS_IEN))
        done_irq_en <= wdata[`SACS_B_DONE];
      // Completion sets the flag even when software clears it that cycle
      if (finish)
        conversion_done_flag <= 1'b1; // [RL8]
      else if (wr & (avs_address == `SACS_OFS_FLAG))
        conversion_done_flag <= wdata[`SACS_B_DONE];
      case (state)
        ST_IDLE: begin
          tad_cnt <= 4'd0;
          conv_channel <= converter_control_reg[`SACS_B_CH_HI:`SACS_B_CH_LO]; // [RL22]
          if (go & on & ~wr_ctrl) begin // [RL7] [RL13]
            state <= ST_CONV;
            sar_word <= 10'd0;
          end else if (go & ~on & ~wr_ctrl)
            converter_control_reg[`SACS_B_GO] <= 1'b0;
        end
        ST_CONV: begin
          if (sw_abort | ~on) begin
            // Partial result is dropped; result registers untouched
            state <= ST_ABORT; // [RL9]
            tad_cnt <= 4'd0;
            converter_control_reg[`SACS_B_GO] <= 1'b0;
          end else if (tad_tick) begin
            tad_cnt <= tad_cnt + 4'd1; // [RL1]
            if (tad_cnt != 4'd0)
              sar_word[`SACS_BITS - tad_cnt] <= cmp_val; // [RL20]
            if (finish) begin
              state <= ST_IDLE;
              converter_control_reg[`SACS_B_GO] <= 1'b0; // [RL8] [RL21]
              if (converter_control_reg[`SACS_B_JUST]) begin // [RL12] [RL19] [RL21]
                result_high <= {6'd0, sar_word[9:8]};
                result_low <= {sar_word[7:1], cmp_val};
              end else begin
                result_high <= sar_word[9:2];
                result_low <= {sar_word[1], cmp_val, 6'd0};
              end
            end
          end
        end
        ST_ABORT: begin
          if (tad_tick) begin
            tad_cnt <= tad_cnt + 4'd1;
            if (tad_cnt == `SACS_ABORT_TAD - 4'd1) begin
              state <= ST_IDLE; // [RL10]
              tad_cnt <= 4'd0;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // Analog side controls; the hold node is never discharged
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog_power_on <= 1'b0;
      mux_channel <= 2'd0;
      ref_ext_sel <= 1'b0;
      sample_en <= 1'b0;
      sar_trial_en <= 1'b0;
      sar_bit_idx <= 4'd0;
      pin_analog_select <= 4'h0;
      pin_digital_disable <= 4'h0;
      conv_irq <= 1'b0;
    end else begin
      analog_power_on <= on; // [RL13]
      mux_channel <= conv_channel; // [RL5]
      ref_ext_sel <= converter_control_reg[`SACS_B_VREF]; // [RL6]
      sample_en <= on & (state == ST_IDLE); // [RL10] [RL18]
      sar_trial_en <= (state == ST_CONV) & (tad_cnt != 4'd0);
      sar_bit_idx <= `SACS_CONV_TAD - 4'd1 - tad_cnt;
      pin_analog_select <= analog_pin_select_reg[3:0]; // [RL14]
      pin_digital_disable <= analog_pin_select_reg[3:0]; // [RL14]
      conv_irq <= conversion_done_flag & done_irq_en; // [RL8]
    end
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (rd) begin
      case (avs_address)
        `SACS_OFS_CTRL: avs_readdata <= {24'd0, converter_control_reg};
        `SACS_OFS_PINSEL: avs_readdata <= {24'd0, analog_pin_select_reg};
        `SACS_OFS_RES_HI: avs_readdata <= {24'd0, result_high};
        `SACS_OFS_RES_LO: avs_readdata <= {24'd0, result_low};
        `SACS_OFS_FLAG: avs_readdata <= {24'd0, 1'b0, conversion_done_flag, 6'd0};
        `SACS_OFS_IEN: avs_readdata <= {24'd0, 1'b0, done_irq_en, 6'd0};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // sacs_top
`default_nettype wire

// >>> hdl/sacs_consts.vh
// Constants for the converter control sequencer
// Overview of operation
// [RL1] A full conversion takes eleven conversion bit periods.
// [RL2] Clock select field sits at analog select bits 6 to 4, writable.
// [RL3] Clock select decodes 2,8,32,4,16,64 divides; x11 picks internal RC clock.
// [RL4] Software picks a setting with bit period of at least 1.6 us.
// [RL5] Channel select bits 3 to 2 route one of four inputs to hold.
// [RL6] Reference select bit 6: set uses reference pin, clear uses supply.
// [RL7] Writing go bit 1 starts conversion; reads one while converting.
// [RL8] On completion go clears, done flag sets, interrupt request if enabled.
// [RL9] Clearing go mid-conversion aborts; result keeps previous value.
// [RL10] After abort wait two bit periods, then acquire selected channel.
// [RL11] Software should not set go in the same write that enables converter.
// [RL12] Justify bit 7: one right justified, zero left justified.
// [RL13] Converter on bit 0 powers the converter; zero shuts it off.
// [RL14] Pin analog bits 3 to 0 make pins analog, disabling digital functions.
// [RL15] Software sets analog pins' direction to input.
// [RL16] Control bits 5 to 4 and analog select bit 7 read zero.
// [RL17] Software waits acquisition time after channel change before starting.
// [RL18] Hold capacitor is never discharged at conversion end.
// [RL19] Left: eight high bits high, two low; right: two high, eight low.
// [RL20] Result is ten bits by successive approximation across two registers.
// [RL21] Both result registers, go clear and done set update in one cycle; an abort in the finishing cycle sets done but keeps the old results.
// [RL22] Channel writes during conversion take effect only after it ends.
`ifndef SACS_CONSTS_VH
`define SACS_CONSTS_VH
`define SACS_OFS_CTRL 8'h1f
`define SACS_OFS_PINSEL 8'h9f
`define SACS_OFS_RES_HI 8'h1e
`define SACS_OFS_RES_LO 8'h9e
`define SACS_OFS_FLAG 8'h0c
`define SACS_OFS_IEN 8'h8c
`define SACS_CTRL_RST 8'h00
`define SACS_PINSEL_RST 8'h0f
`define SACS_CTRL_MASK 8'hcf
`define SACS_PINSEL_MASK 8'h7f
`define SACS_B_ON 0
`define SACS_B_GO 1
`define SACS_B_CH_LO 2
`define SACS_B_CH_HI 3
`define SACS_B_VREF 6
`define SACS_B_JUST 7
`define SACS_B_CS_LO 4
`define SACS_B_CS_HI 6
`define SACS_B_DONE 6
`define SACS_CONV_TAD 4'd11
`define SACS_ABORT_TAD 4'd2
`define SACS_BITS 10
`endif

// >>> hdl/sacs_tad_gen.v
// Conversion bit period enable generator
`timescale 1ns/1ps
`default_nettype none
`include "sacs_consts.vh"
module sacs_tad_gen #(
  parameter RC_DIV = 40
) (
  input wire clk_sys,
  input wire rst_n,
  input wire run,
  input wire [2:0] clk_sel,
  output reg tad_tick
);
  reg [6:0] cnt;
  reg [6:0] limit;
  // Internal RC clock is modelled as a fixed divide of the system clock
  always @* begin
    case (clk_sel) // [RL3]
      3'b000: limit = 7'd1;
      3'b001: limit = 7'd7;
      3'b010: limit = 7'd31;
      3'b100: limit = 7'd3;
      3'b101: limit = 7'd15;
      3'b110: limit = 7'd63;
      default: limit = RC_DIV[6:0] - 7'd1;
    endcase
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 7'd0;
      tad_tick <= 1'b0;
    end else if (!run) begin
      cnt <= 7'd0;
      tad_tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt <= 7'd0;
      tad_tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'd1;
      tad_tick <= 1'b0;
    end
  end
endmodule // sacs_tad_gen
`default_nettype wire

// >>> sim/sacs_props.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sacs_props (
  input wire clk_sys,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire analog_power_on,
  input wire [1:0] mux_channel,
  input wire sample_en,
  input wire sar_trial_en,
  input wire [3:0] pin_analog_select,
  input wire [3:0] pin_digital_disable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_stall; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_rd_take; avs_read && !avs_waitrequest; endsequence
  sequence s_trial2; sar_trial_en ##1 sar_trial_en; endsequence
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no stall in first cycle");
  a_wait_second: assert property (s_stall |=> !avs_waitrequest)
    else $error("stall past second cycle");
  a_read_upper: assert property (s_rd_take |=> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_read_stands: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved");
  a_pin_disable: assert property (pin_digital_disable == pin_analog_select)
    else $error("digital disable differs");
  a_off_idle: assert property (!analog_power_on [*2] |-> !sample_en && !sar_trial_en)
    else $error("activity while off");
  a_no_overlap: assert property (!(sample_en && sar_trial_en))
    else $error("sampling during trial");
  a_mux_hold: assert property (s_trial2 |-> $stable(mux_channel))
    else $error("channel moved in conversion");
  a_acq_resume: assert property ($fell(sar_trial_en) && analog_power_on
    |-> ##[1:300] (sample_en || !analog_power_on))
    else $error("acquisition did not resume");
endmodule // sacs_props
bind sacs_top sacs_props u_props (.clk_sys, .rst_n, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .analog_power_on, .mux_channel, .sample_en, .sar_trial_en,
  .pin_analog_select, .pin_digital_disable);
`default_nettype wire

// >>> sim/sacs_sar_model.sv
// Comparator stand-in answering each bit trial from a fixed level
`timescale 1ns/1ps
`default_nettype none
module sacs_sar_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sar_trial_en,
  input wire logic [3:0] sar_bit_idx,
  input wire logic [9:0] level,
  output logic comparator_out
);
  logic [3:0] last_idx;
  logic in_trial;
  logic flip;
  int k;
  // Toggles outside trials so a stray sample never matches by luck
  assign comparator_out = sar_trial_en ? level[k] : flip;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      k <= 9;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      if (!sar_trial_en) k <= 9;
      else if (in_trial && sar_bit_idx != last_idx) k <= k - 1;
    end
  end
  always @(posedge clk_sys) begin
    in_trial <= sar_trial_en;
    last_idx <= sar_bit_idx;
  end
endmodule // sacs_sar_model
`default_nettype wire

// >>> sim/sacs_top_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sacs_top_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, analog_power_on, ref_ext_sel, sample_en, sar_trial_en;
  logic comparator_out, conv_irq;
  logic [1:0] mux_channel;
  logic [3:0] sar_bit_idx, pin_analog_select, pin_digital_disable;
  logic [9:0] level = 10'h000;
  logic [31:0] seed = 32'hd81e_3675;
  logic [31:0] r;
  logic [15:0] e;
  int errors = 0;
  int comparisons = 0;
  int q[$];
  int dv[8] = '{2, 8, 32, 4, 4, 16, 64, 4};
  int ord[8] = '{0, 1, 2, 3, 4, 5, 7, 6};
  int cs, d, t;
  always #50 clk_sys = ~clk_sys;
  sacs_top #(.RC_DIV(4)) DUT (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .analog_power_on,
    .mux_channel, .ref_ext_sel, .sample_en, .sar_trial_en, .sar_bit_idx, .comparator_out,
    .pin_analog_select, .pin_digital_disable, .conv_irq);
  sacs_sar_model u_model (.clk_sys, .rst_n, .sar_trial_en, .sar_bit_idx, .level,
    .comparator_out);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Holds the request until the edge that sees waitrequest low, then lets one edge pass
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dt);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, dt};
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    report_and_stop();
  end
  initial begin
    step(3);
    rst_n <= 1'b1;
    step(2);
    acc(0, 8'h1f, 0); chk(r, 32'h00);
    acc(0, 8'h9f, 0); chk(r, 32'h0f);
    chk(pin_analog_select, 4'hf);
    acc(0, 8'h55, 0); chk(r, 32'h00);
    acc(1, 8'h9f, 8'hff); acc(0, 8'h9f, 0); chk(r, 32'h7f);
    avs_byteenable <= 4'he;
    acc(1, 8'h9f, 8'h00);
    avs_byteenable <= 4'hf;
    acc(0, 8'h9f, 0); chk(r, 32'h7f);
    acc(1, 8'h1f, 8'hf1); acc(0, 8'h1f, 0); chk(r, 32'hc1);
    chk({ref_ext_sel, analog_power_on}, 2'b11);
    acc(1, 8'h1f, 8'h00); step(2); chk({ref_ext_sel, analog_power_on}, 2'b00);
    seed = lfsr(seed);
    acc(1, 8'h9f, {4'h0, seed[3:0]}); step(2); chk(pin_digital_disable, seed[3:0]);
    for (int i = 0; i < 8; i++) begin
      cs = ord[i];
      d = dv[cs];
      seed = lfsr(seed);
      level <= seed[9:0];
      acc(1, 8'h9f, {1'b0, cs[2:0], 4'h0});
      acc(1, 8'h8c, {1'b0, cs[1], 6'h00});
      acc(1, 8'h1f, {cs[0], 3'b000, cs[1:0], 2'b01});
      step(20);
      acc(1, 8'h1f, {cs[0], 3'b000, cs[1:0], 2'b11});
      t = 0;
      do begin
        acc(0, 8'h1f, 0);
        t += 3;
      end while (r[1] === 1'b1 && t < 2000);
      chk(t >= 11 * d - 2 && t <= 12 * d + 10, 1'b1);
      chk(mux_channel, cs[1:0]);
      q.push_back(cs[0] ? {6'h00, seed[9:0]} : {seed[9:0], 6'h00});
      e = q.pop_front();
      if (d >= 16) begin
        acc(0, 8'h1e, 0); chk(r, e[15:8]);
        acc(0, 8'h9e, 0); chk(r, e[7:0]);
      end
      acc(0, 8'h0c, 0); chk(r, 32'h40);
      step(1); chk(conv_irq, cs[1]);
      acc(1, 8'h0c, 8'h00); acc(0, 8'h0c, 0); chk(r, 32'h00);
    end
    acc(1, 8'h1f, 8'h07);
    step(100);
    acc(1, 8'h1f, 8'h0f); chk(mux_channel, 2'd1);
    acc(1, 8'h1f, 8'h0d); step(2); chk(sample_en, 1'b0);
    acc(0, 8'h1f, 0); chk(r, 32'h0d);
    step(110); chk(sample_en, 1'b0);
    step(152); chk({sample_en, mux_channel}, 3'b111);
    acc(0, 8'h1e, 0); chk(r, e[15:8]);
    acc(0, 8'h9e, 0); chk(r, e[7:0]);
    report_and_stop();
  end
endmodule // sacs_top_bench
`default_nettype wire
